//--- hdl/framer_event_irq.sv
// Receive E1 framer event interrupt enable, status and signaling change logging
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
`include "framer_irq_regs.svh"

module framer_event_irq
  import framer_irq_pkg::*;
#(
  parameter int SIG_CH = `SIG_CHANNELS
)
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  // Detector indications from the receive framer
  input  wire framer_ind_t ind_i,
  // Register port
  input  wire reg_req_t    req_i,
  output logic [7:0]       rdata_o,
  // Interrupt
  output logic             irq_o
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0]        framer_event_enable;
  logic [7:0]        event_status;
  logic [7:0]        framer_ctrl;
  logic [31:0]       sig_changed;
  logic              cas_mf_q;
  logic              oof_q;
  logic [4:0]        national_q;
  logic [3:0]        abcd_q [SIG_CH];
  logic              ind_primed;
  logic [7:0]        rdata;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  wire wr_enable  = req_i.wr && (req_i.addr == `REG_EVENT_ENABLE);
  wire wr_clear   = req_i.wr && (req_i.addr == `REG_EVENT_CLEAR);
  wire wr_ctrl    = req_i.wr && (req_i.addr == `REG_FRAMER_CTRL);
  wire rd_status  = req_i.rd && (req_i.addr == `REG_EVENT_STATUS);
  wire rd_sig0    = req_i.rd && (req_i.addr == `REG_SIG_CHG_0);
  wire rd_sig1    = req_i.rd && (req_i.addr == `REG_SIG_CHG_1);
  wire rd_sig2    = req_i.rd && (req_i.addr == `REG_SIG_CHG_2);
  wire rd_sig3    = req_i.rd && (req_i.addr == `REG_SIG_CHG_3);
  wire cas_on     = framer_ctrl[`CTRL_CAS_ON_BIT];

  // ----------------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------------
  // Edges are ignored until the first sample is taken, so reset release raises nothing
  wire ev_cas_mf  = ind_primed && (ind_i.cas_mf_lost != cas_mf_q);
  wire ev_nat     = ind_primed && (ind_i.national_bits != national_q);
  wire ev_oof     = ind_primed && (ind_i.oof != oof_q);
  wire ch_ok      = ind_i.sig_valid && (int'(ind_i.sig_channel) < SIG_CH);
  wire ev_sig     = cas_on && ch_ok
                    && (ind_i.sig_abcd != abcd_q[ind_i.sig_channel]);

  logic [7:0] events;
  assign events[`EV_CAS_MF]     = ev_cas_mf;
  assign events[`EV_NATIONAL]   = ev_nat;
  assign events[`EV_SIGNALING]  = ev_sig;
  assign events[`EV_ALIGN_MOVE] = ind_i.align_move;
  assign events[`EV_OOF]        = ev_oof;
  assign events[`EV_MIMIC]      = ind_i.mimic;
  assign events[`EV_CRC4]       = ind_i.crc4_error;
  // Independent of the out of frame state: an errored bit is not a sync loss
  assign events[`EV_FAS_ERR]    = ind_i.fas_error;

  // Set wins over a read or write clear in the same cycle
  wire [7:0]  clr_mask          = rd_status ? 8'hFF : (wr_clear ? req_i.wdata : 8'h00);
  wire [7:0]  next_event_status = (event_status & ~clr_mask) | events;

  wire [31:0] sig_set  = ev_sig ? (32'h0000_0001 << ind_i.sig_channel) : 32'h0000_0000;
  wire [31:0] sig_clr  = {rd_sig3 ? 8'hFF : 8'h00, rd_sig2 ? 8'hFF : 8'h00,
                          rd_sig1 ? 8'hFF : 8'h00, rd_sig0 ? 8'hFF : 8'h00};
  wire [31:0] next_sig_changed = (sig_changed & ~sig_clr) | sig_set;

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  always_comb
  begin
    unique case (req_i.addr)
      `REG_EVENT_STATUS: rdata = event_status;
      `REG_EVENT_ENABLE: rdata = framer_event_enable;
      `REG_SIG_CHG_0:    rdata = sig_changed[7:0];
      `REG_SIG_CHG_1:    rdata = sig_changed[15:8];
      `REG_SIG_CHG_2:    rdata = sig_changed[23:16];
      `REG_SIG_CHG_3:    rdata = sig_changed[31:24];
      `REG_FRAMER_CTRL:  rdata = framer_ctrl;
      default:           rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------
  // Control and status
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      framer_event_enable <= `EVENT_ENABLE_RST;
      framer_ctrl         <= `FRAMER_CTRL_RST;
      event_status        <= `EVENT_STATUS_RST;
      sig_changed         <= `SIG_CHG_RST;
      rdata_o             <= 8'h00;
      irq_o               <= 1'b0;
    end
    else
    begin
      if (wr_enable)
        framer_event_enable <= req_i.wdata;
      if (wr_ctrl)
        framer_ctrl <= req_i.wdata;
      event_status <= next_event_status;
      sig_changed  <= next_sig_changed;
      rdata_o      <= req_i.rd ? rdata : 8'h00;
      irq_o        <= |(next_event_status & framer_event_enable);
    end
  end

  // ----------------------------------------------------------------------
  // Previous indication samples
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      ind_primed <= 1'b0;
      cas_mf_q   <= 1'b0;
      oof_q      <= 1'b0;
      national_q <= 5'h00;
    end
    else
    begin
      ind_primed <= 1'b1;
      cas_mf_q   <= ind_i.cas_mf_lost;
      oof_q      <= ind_i.oof;
      national_q <= ind_i.national_bits;
    end
  end

  // Last seen ABCD per channel; a RAM-like array, so no reset
  always_ff @(posedge core_clk_i)
  begin
    if (ch_ok)
      abcd_q[ind_i.sig_channel] <= ind_i.sig_abcd;
  end

endmodule

//--- hdl/framer_irq_regs.svh
// Register offsets, field positions and reset values of the framer event interrupt block
`ifndef FRAMER_IRQ_REGS_SVH
`define FRAMER_IRQ_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define REG_EVENT_STATUS   8'h00
`define REG_EVENT_ENABLE   8'h01
`define REG_EVENT_CLEAR    8'h02
`define REG_SIG_CHG_0      8'h03
`define REG_SIG_CHG_1      8'h04
`define REG_SIG_CHG_2      8'h05
`define REG_SIG_CHG_3      8'h06
`define REG_FRAMER_CTRL    8'h07

// ----------------------------------------------------------------------
// Event bit positions
// ----------------------------------------------------------------------
`define EV_CAS_MF          7
`define EV_NATIONAL        6
`define EV_SIGNALING       5
`define EV_ALIGN_MOVE      4
`define EV_OOF             3
`define EV_MIMIC           2
`define EV_CRC4            1
`define EV_FAS_ERR         0

// ----------------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------------
`define EVENT_ENABLE_RST   8'h00
`define EVENT_STATUS_RST   8'h00
`define FRAMER_CTRL_RST    8'h00
`define CTRL_CAS_ON_BIT    0
`define SIG_CHANNELS       30
`define SIG_CHG_RST        32'h0000_0000

`endif

//--- hdl/framer_irq_pkg.sv
// Types shared by the framer event interrupt block
package framer_irq_pkg;

  // Raw indications from the receive framer detectors
  typedef struct packed {
    logic        cas_mf_lost;
    logic [4:0]  national_bits;
    logic        sig_valid;
    logic [4:0]  sig_channel;
    logic [3:0]  sig_abcd;
    logic        align_move;
    logic        oof;
    logic        mimic;
    logic        crc4_error;
    logic        fas_error;
  } framer_ind_t;

  // Register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

endpackage

//--- dv/e1_line_model.sv
// Line side model that drives the detector indications
`timescale 1ns/10ps
module e1_line_model
  import framer_irq_pkg::*;
(
  // Clock
  input  wire logic  core_clk_i,
  // Indications
  output framer_ind_t ind_o
);
  // ----------------------------------------
  // Event generation
  // ----------------------------------------
  initial ind_o = '0;
  // Single-bit levels toggle so both edges get exercised, the national bits count up; the rest pulse one cycle
  task automatic fire(input int b, input logic [4:0] ch, input logic [3:0] v);
    @(posedge core_clk_i);
    case (b)
      7: ind_o.cas_mf_lost <= ~ind_o.cas_mf_lost;
      6: ind_o.national_bits <= ind_o.national_bits + 5'h01;
      5: {ind_o.sig_valid, ind_o.sig_channel, ind_o.sig_abcd} <= {1'b1, ch, v};
      4: ind_o.align_move <= 1'b1;
      3: ind_o.oof <= ~ind_o.oof;
      2: ind_o.mimic <= 1'b1;
      1: ind_o.crc4_error <= 1'b1;
      default: ind_o.fas_error <= 1'b1;
    endcase
    @(posedge core_clk_i);
    {ind_o.sig_valid, ind_o.align_move, ind_o.mimic, ind_o.crc4_error, ind_o.fas_error} <= '0;
  endtask
endmodule

//--- dv/framer_event_irq_props.sv
// Concurrent checks on the framer event interrupt ports
`timescale 1ns/10ps
`include "framer_irq_regs.svh"
module framer_event_irq_props
  import framer_irq_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        resetn_i,
  input wire framer_ind_t ind_i,
  input wire reg_req_t    req_i,
  input wire logic [7:0]  rdata_o,
  input wire logic        irq_o
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic [7:0] en_q;
  wire        pulse_any = ind_i.sig_valid | ind_i.align_move | ind_i.mimic
                          | ind_i.crc4_error | ind_i.fas_error;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  // Shadow enable, so the checks know which events may raise the interrupt
  always_ff @(posedge core_clk_i)
    if (!resetn_i)
      en_q <= 8'h00;
    else if (req_i.wr && req_i.addr == `REG_EVENT_ENABLE)
      en_q <= req_i.wdata;
  property p_rdata_idle;
    !$past(req_i.rd) |-> rdata_o == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not idle");
  property p_irq_off;
    $past(en_q) == 8'h00 |-> !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
  property p_crc;
    ind_i.crc4_error && en_q[`EV_CRC4] |=> irq_o;
  endproperty
  a_crc: assert property (p_crc) else $error("crc irq missing");
  property p_fas;
    ind_i.fas_error && en_q[`EV_FAS_ERR] |=> irq_o;
  endproperty
  a_fas: assert property (p_fas) else $error("fas irq missing");
  property p_oof;
    $changed(ind_i.oof) && $past(resetn_i) && en_q[`EV_OOF] |=> irq_o;
  endproperty
  a_oof: assert property (p_oof) else $error("oof irq missing");
  property p_cas;
    $changed(ind_i.cas_mf_lost) && $past(resetn_i) && en_q[`EV_CAS_MF] |=> irq_o;
  endproperty
  a_cas: assert property (p_cas) else $error("cas irq missing");
  property p_nat;
    $changed(ind_i.national_bits) && $past(resetn_i) && en_q[`EV_NATIONAL] |=> irq_o;
  endproperty
  a_nat: assert property (p_nat) else $error("national irq missing");
  property p_rd_clr;
    req_i.rd && req_i.addr == `REG_EVENT_STATUS && !pulse_any && $stable(ind_i) |=> !irq_o;
  endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("irq after status read");
endmodule

//--- dv/framer_event_irq_tb.sv
// Self-checking bench of the framer event interrupt block
`timescale 1ns/10ps
`include "framer_irq_regs.svh"
module framer_event_irq_tb
  import framer_irq_pkg::*;
;
  logic        core_clk_i;
  logic        resetn_i;
  reg_req_t    req_i;
  framer_ind_t ind_i;
  logic [7:0]  rdata_o;
  logic        irq_o;
  int          err_total;
  int          checked;
  int          cyc;
  framer_event_irq u_framer_event_irq (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .ind_i(ind_i), .req_i(req_i), .rdata_o(rdata_o), .irq_o(irq_o));
  e1_line_model u_e1_line_model (.core_clk_i(core_clk_i), .ind_o(ind_i));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string nm);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_i);
    req_i.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    req_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i);
    req_i.rd <= 1'b0;
    #1 chk(rdata_o, e, "rdata");
  endtask
  task automatic end_of_test();
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_total = err_total + 1;
      end_of_test();
    end
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    resetn_i = 1'b0;
    req_i = '0;
    err_total = 0;
    checked = 0;
    cyc = 0;
    repeat (3) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    rd(`REG_EVENT_ENABLE, 8'h00);
    wr(8'hFF, 8'h5A);
    rd(8'hFF, 8'h00);
    rd(`REG_EVENT_ENABLE, 8'h00);
    wr(`REG_EVENT_ENABLE, 8'hA5);
    rd(`REG_EVENT_ENABLE, 8'hA5);
    // Channel history is unreset, so prime every channel while signaling is off
    for (int c = 0; c < 30; c++)
      u_e1_line_model.fire(5, c[4:0], 4'h0);
    rd(`REG_EVENT_STATUS, 8'h00);
    rd(`REG_SIG_CHG_3, 8'h00);
    wr(`REG_FRAMER_CTRL, 8'h01);
    for (int p = 0; p < 2; p++)
    begin
      wr(`REG_EVENT_ENABLE, p ? 8'h00 : 8'hFF);
      for (int b = 0; b < 8; b++)
      begin
        u_e1_line_model.fire(b, 5'd29, 4'h5 + p[3:0]);
        #1 chk({7'h00, irq_o}, p ? 8'h00 : 8'h01, "irq");
        rd(`REG_EVENT_STATUS, 8'h01 << b);
        chk({7'h00, irq_o}, 8'h00, "irq_drop");
        if (b == 5)
          rd(`REG_SIG_CHG_3, 8'h20);
      end
    end
    wr(`REG_EVENT_ENABLE, 8'h02);
    u_e1_line_model.fire(1, 5'd0, 4'h0);
    #1 chk({7'h00, irq_o}, 8'h01, "irq_crc");
    wr(`REG_EVENT_CLEAR, 8'h02);
    #1 chk({7'h00, irq_o}, 8'h00, "irq_clear");
    rd(`REG_EVENT_STATUS, 8'h00);
    end_of_test();
  end
endmodule
bind framer_event_irq framer_event_irq_props u_framer_event_irq_props (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .ind_i(ind_i),
  .req_i(req_i), .rdata_o(rdata_o), .irq_o(irq_o));
